// file: design/scs_strap_capture.sv
// Strap capture: pin synchronisers, capture at reset release, decode
`timescale 1ns/1ps
module scs_strap_capture (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic strap_select_pin_i,
	input wire logic [5:0] hard_strap_pins_i,
	input wire logic [1:0] mid_level_input_i,
	scs_strap_if.producer strap
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic rst_d;
	logic cap_sel;
	logic [5:0] cap_pins;
	logic [1:0] cap_mid;

	// Two stages, free of reset so pins are sampled through reset
	always_ff @(posedge clk_i) begin
		sync1 <= {strap_select_pin_i, mid_level_input_i, hard_strap_pins_i};
		sync2 <= sync1;
	end

	// Delayed reset marks the release edge
	always_ff @(posedge clk_i) begin
		rst_d <= rst_i;
	end

	assign strap.cap_pulse = rst_d & ~rst_i;

	// ************************************************************
	// Capture at reset release only
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_sel <= 1'b0;
			cap_pins <= 6'h00;
			cap_mid <= 2'h0;
		end else if (strap.cap_pulse) begin
			cap_sel <= sync2[8];
			cap_mid <= sync2[7:6];
			cap_pins <= sync2[5:0];
		end
	end

	// ************************************************************
	// Decode of captured straps
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap.strap_select_flag <= 1'b0;
			strap.soft_strap_code <= scs_pkg::SOFT_CODE_RST;
			strap.hard_strap_code <= scs_pkg::HARD_CODE_RST;
			strap.bus_address_field <= 2'h0;
		end else begin
			strap.strap_select_flag <= cap_sel;
			// Soft code zero in hard mode
			strap.soft_strap_code <= cap_sel ? scs_pkg::SOFT_CODE_RST :
				scs_pkg::soft_pair_code(cap_pins[3], cap_pins[2], cap_mid[1]);
			// Hard code zero in soft mode
			strap.hard_strap_code <= cap_sel ? cap_pins : scs_pkg::HARD_CODE_RST;
			strap.bus_address_field <= scs_pkg::addr_low_bits(cap_pins[1], cap_mid[0]);
		end
	end

endmodule

// file: design/scs_top.sv
// Strap capture and configuration status registers behind a Wishbone slave
//
// Summary of operation
// - Strap settings are latched when reset is released and at no other time.
// - Soft strap status bit 7 shows captured strap select level, 1 is hard mode.
// - Soft mode bits 6:4 encode pin 3 and three-level pin 2 as codes 0 to 5.
// - Hard mode bits 7:2 of hard strap status hold pins 5 to 0.
// - In soft mode the hard strap code reads zero.
// - Bus address in bits 7:1, bits 7:3 from memory, default 0x50, bits 2:1 from pin 1.
// - Image revision comes from memory or fixed image, whichever is active.
// - Image revision is reloaded after every reset.
// - Image revision is reloaded whenever a memory commit completes in the run state.
// - All these registers are read-only; writes have no effect.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module scs_top (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Strap pins
	input wire logic strap_select_pin_i,
	input wire logic [5:0] hard_strap_pins_i,
	input wire logic [1:0] mid_level_input_i,
	// Non-volatile memory and fixed image sources
	input wire logic [6:0] nvm_bus_addr_i,
	input wire logic [7:0] nvm_image_rev_i,
	input wire logic [7:0] rom_image_rev_i,
	input wire logic image_src_nvm_i,
	input wire logic commit_done_i
);

	// ************************************************************
	// Types and declarations
	// ************************************************************
	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN = 3'b100
	} scs_state_e;

	scs_state_e state;
	scs_state_e next_state;
	logic [7:0] bus_address_status;
	logic [7:0] image_revision;
	logic [7:0] soft_strap_status;
	logic [7:0] hard_strap_status;
	logic [5:0] bus_idx;
	logic bus_req;
	logic [7:0] next_rd;
	logic [7:0] active_rev;
	logic cap_seen;

	scs_strap_if strap ();

	// ************************************************************
	// Strap capture unit
	// ************************************************************
	scs_strap_capture u_capture (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.strap_select_pin_i(strap_select_pin_i),
		.hard_strap_pins_i(hard_strap_pins_i),
		.mid_level_input_i(mid_level_input_i),
		.strap(strap.producer)
	);

	// ************************************************************
	// Load sequencer
	// ************************************************************
	// Capture marker, one cycle after the capture pulse
	// Loading on the pulse itself would take the decode still in its reset state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_seen <= 1'b0;
		end else begin
			cap_seen <= strap.cap_pulse;
		end
	end

	// Wait for capture, load once, then run
	always_comb begin
		next_state = state;
		case (state)
			ST_WAIT: begin
				if (cap_seen) begin
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				next_state = ST_RUN;
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Address and revision loads
	// ************************************************************
	// Revision of whichever image is active
	assign active_rev = image_src_nvm_i ? nvm_image_rev_i : rom_image_rev_i;

	// Bus address: upper bits from memory, low bits from pin 1
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_address_status <= scs_pkg::BUS_ADDR_RST;
		end else if (state == ST_LOAD) begin
			bus_address_status <= {nvm_bus_addr_i[6:2], strap.bus_address_field, 1'b0};
		end
	end

	// Revision reload after reset and on commit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			image_revision <= scs_pkg::IMAGE_REV_RST;
		end else if (state == ST_LOAD) begin
			image_revision <= active_rev;
		end else if (state == ST_RUN && commit_done_i) begin
			image_revision <= active_rev;
		end
	end

	// ************************************************************
	// Status views
	// ************************************************************
	// Reserved bits tied to zero
	assign soft_strap_status = {strap.strap_select_flag, strap.soft_strap_code, 4'h0};
	assign hard_strap_status = {strap.hard_strap_code, 2'h0};

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	assign bus_idx = wb_adr_i[7:2];
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Read mux; unmapped indices return zero
	always_comb begin
		case (bus_idx)
			scs_pkg::IDX_SOFT_STRAP: next_rd = soft_strap_status;
			scs_pkg::IDX_HARD_STRAP: next_rd = hard_strap_status;
			scs_pkg::IDX_BUS_ADDR: next_rd = bus_address_status;
			scs_pkg::IDX_IMAGE_REV: next_rd = image_revision;
			default: next_rd = 8'h00;
		endcase
	end

	// One-cycle ack; writes are acknowledged and dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data, narrow value in the low byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, next_rd};
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic rd_ack;
	logic [5:0] ack_idx;
	logic [3:0] ack_sel;
	logic [31:0] ack_wdat;

	// Index of the request being answered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ack <= 1'b0;
			ack_idx <= 6'h00;
			ack_sel <= 4'h0;
			ack_wdat <= 32'h0000_0000;
		end else begin
			rd_ack <= bus_req & ~wb_we_i;
			ack_idx <= bus_idx;
			ack_sel <= wb_sel_i;
			ack_wdat <= wb_dat_i;
		end
	end

	sequence s_release;
		$fell(rst_i);
	endsequence

	sequence s_loaded;
		(state == ST_LOAD) ##1 (state == ST_RUN);
	endsequence

	a_cap_hold: assert property (
		(state != ST_LOAD) |-> $stable(strap.strap_select_flag)
			&& $stable(strap.soft_strap_code) && $stable(strap.hard_strap_code)
	) else $error("strap flag changed outside capture");

	a_sel_readback: assert property (
		(rd_ack && ack_idx == scs_pkg::IDX_SOFT_STRAP) |->
			wb_dat_o[scs_pkg::SEL_FLAG_BIT] == strap.strap_select_flag
	) else $error("soft strap bit 7 differs from strap select");

	a_soft_range: assert property (
		strap.soft_strap_code <= scs_pkg::SOFT_CODE_MAX
	) else $error("soft strap code above five");

	a_hard_readback: assert property (
		(rd_ack && ack_idx == scs_pkg::IDX_HARD_STRAP) |->
			wb_dat_o[7:2] == strap.hard_strap_code && wb_dat_o[1:0] == 2'h0
	) else $error("hard strap read differs from code");

	a_hard_zero: assert property (
		(state == ST_RUN && !strap.strap_select_flag) |-> strap.hard_strap_code == 6'h00
	) else $error("hard code nonzero in soft mode");

	a_addr_field: assert property (
		s_loaded |-> bus_address_status[2:1] == strap.bus_address_field
			&& bus_address_status[2:1] != 2'h2 && bus_address_status[0] == 1'b0
	) else $error("bus address low bits wrong");

	a_rev_source: assert property (
		(state == ST_LOAD) |=> image_revision == $past(active_rev)
	) else $error("revision not from active image");

	a_rev_reload: assert property (
		s_release |-> ##[1:4] (state == ST_RUN)
	) else $error("revision not reloaded after reset");

	a_rev_commit: assert property (
		(state == ST_RUN && commit_done_i) |=> image_revision == $past(active_rev)
	) else $error("revision not reloaded on commit");

	a_write_ignored: assert property (
		(bus_req && wb_we_i) |=> $stable(bus_address_status) && $stable(image_revision)
			&& wb_ack_o && wb_dat_o == 32'h0000_0000
	) else $error("write changed a read-only register");

	a_rsvd_zero: assert property (
		rd_ack |-> wb_dat_o[31:8] == 24'h00_0000
			&& (ack_idx != scs_pkg::IDX_SOFT_STRAP || wb_dat_o[3:0] == 4'h0)
			&& (!strap.strap_select_flag || ack_idx != scs_pkg::IDX_SOFT_STRAP
				|| wb_dat_o[6:4] == 3'h0)
	) else $error("reserved or masked bits nonzero");

	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held longer than one cycle");

	a_ack_timing: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
	) else $error("request not answered next cycle");

	a_addr_default: assert property (
		(state == ST_WAIT) |-> bus_address_status == scs_pkg::BUS_ADDR_RST
	) else $error("bus address not at default before load");

	a_rev_hold: assert property (
		(state == ST_RUN && !commit_done_i) |=> $stable(image_revision)
	) else $error("revision changed without a reload");

	a_soft_masked: assert property (
		(state == ST_RUN && strap.strap_select_flag)
			|-> strap.soft_strap_code == scs_pkg::SOFT_CODE_RST
	) else $error("soft code nonzero in hard mode");

	a_load_order: assert property (
		(state == ST_WAIT && cap_seen) |=> (state == ST_LOAD)
	) else $error("load not started after capture");

	a_dat_idle: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000
	) else $error("read data nonzero outside acknowledge");

endmodule

// file: pkg/scs_pkg.sv
// Package: constants, register map and decode functions for the strap status block
package scs_pkg;

	// ************************************************************
	// Register map (printed offsets are word indices)
	// ************************************************************
	localparam logic [5:0] IDX_SOFT_STRAP = 6'h08;
	localparam logic [5:0] IDX_HARD_STRAP = 6'h09;
	localparam logic [5:0] IDX_BUS_ADDR = 6'h0A;
	localparam logic [5:0] IDX_IMAGE_REV = 6'h0B;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_LSB = 2;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int SEL_FLAG_BIT = 7;
	localparam int SOFT_CODE_LSB = 4;
	localparam int HARD_CODE_LSB = 2;
	localparam int ADDR_FIELD_LSB = 1;

	// ************************************************************
	// Values after reset and cycle counts
	// ************************************************************
	localparam logic [7:0] BUS_ADDR_RST = 8'h50;
	localparam logic [7:0] IMAGE_REV_RST = 8'h00;
	localparam logic [2:0] SOFT_CODE_RST = 3'h0;
	localparam logic [5:0] HARD_CODE_RST = 6'h00;
	localparam logic [2:0] SOFT_CODE_MAX = 3'h5;
	localparam int SYNC_STAGES = 2;
	localparam int LOAD_CYCLES_MAX = 4;

	// Low address bits from a three-level pin: low 0, mid 1, high 3
	function automatic logic [1:0] addr_low_bits(input logic lvl, input logic mid);
		addr_low_bits = mid ? 2'h1 : (lvl ? 2'h3 : 2'h0);
	endfunction

	// Soft code from a binary pin and a three-level pin
	function automatic logic [2:0] soft_pair_code(input logic hi_lvl, input logic lo_lvl,
		input logic lo_mid);
		logic [2:0] lo;
		lo = lo_mid ? 3'h1 : (lo_lvl ? 3'h2 : 3'h0);
		soft_pair_code = hi_lvl ? 3'(lo + 3'h3) : lo;
	endfunction

endpackage

// file: pkg/scs_strap_if.sv
// Interface: captured strap values passed from the capture unit to the register block
`timescale 1ns/1ps
interface scs_strap_if;
	logic cap_pulse;
	logic strap_select_flag;
	logic [2:0] soft_strap_code;
	logic [5:0] hard_strap_code;
	logic [1:0] bus_address_field;

	modport producer (
		output cap_pulse,
		output strap_select_flag,
		output soft_strap_code,
		output hard_strap_code,
		output bus_address_field
	);
	modport consumer (
		input cap_pulse,
		input strap_select_flag,
		input soft_strap_code,
		input hard_strap_code,
		input bus_address_field
	);
endinterface

// file: test/scs_board_model.sv
// Board model: strap pins of the board, with floating pins that carry no level
`timescale 1ns/1ps
module scs_board_model (
	input wire logic clk_i,
	input wire logic sel_i,
	input wire logic [5:0] lvl_i,
	input wire logic [1:0] mid_i,
	output logic strap_select_pin_o,
	output logic [5:0] pins_o,
	output logic [1:0] mid_o
);
	logic flip = 1'b0;

	// Known levels from time zero
	initial begin
		strap_select_pin_o = 1'b0;
		pins_o = 6'h00;
		mid_o = 2'h0;
	end

	// A floating pin shows a level that changes every cycle, never a held one
	always @(posedge clk_i) begin
		flip <= ~flip;
		strap_select_pin_o <= sel_i;
		mid_o <= mid_i;
		pins_o <= {lvl_i[5:3], mid_i[1] ? ~flip : lvl_i[2], mid_i[0] ? flip : lvl_i[1], lvl_i[0]};
	end
endmodule

// file: test/scs_top_bench.sv
// Testbench: strap capture, image load and read-only status registers
`timescale 1ns/1ps
module scs_top_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic sel = 1'b0;
	logic [5:0] lvl = 6'h00;
	logic [1:0] mid = 2'h0;
	logic pin_sel;
	logic [5:0] pin_lvl;
	logic [1:0] pin_mid;
	logic [6:0] nvm_bus_addr_i = 7'h00;
	logic [7:0] nvm_image_rev_i = 8'h00;
	logic [7:0] rom_image_rev_i = 8'h00;
	logic image_src_nvm_i = 1'b0;
	logic commit_done_i = 1'b0;
	logic [31:0] exp_q[$];
	logic [7:0] exp_soft, exp_hard, exp_addr, exp_rev;
	int num_errors = 0;
	int total_checks = 0;
	int seed = 56793;

	// ************************************************************
	// Device, board and clock
	// ************************************************************
	scs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .strap_select_pin_i(pin_sel),
		.hard_strap_pins_i(pin_lvl), .mid_level_input_i(pin_mid),
		.nvm_bus_addr_i(nvm_bus_addr_i), .nvm_image_rev_i(nvm_image_rev_i),
		.rom_image_rev_i(rom_image_rev_i), .image_src_nvm_i(image_src_nvm_i),
		.commit_done_i(commit_done_i));
	scs_board_model board_u (.clk_i(clk_i), .sel_i(sel), .lvl_i(lvl), .mid_i(mid),
		.strap_select_pin_o(pin_sel), .pins_o(pin_lvl), .mid_o(pin_mid));

	always #2 clk_i = ~clk_i;

	// ************************************************************
	// Bus tasks and result checking
	// ************************************************************
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: read data %h, expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the expected answer is noted first
	task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [7:0] exp);
		int n;
		exp_q.push_back({24'h000000, exp});
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'($random(seed));
		wb_dat_i <= $random(seed);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			$display("Error at %0t: no acknowledge", $time);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	// Oldest note is compared with every acknowledged answer
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1) begin
			check_word(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
		end
	end

	task automatic read_all();
		wb_cycle(8'h20, 1'b0, exp_soft);
		wb_cycle(8'h24, 1'b0, exp_hard);
		wb_cycle(8'h28, 1'b0, exp_addr);
		wb_cycle(8'h2C, 1'b0, exp_rev);
	endtask

	// Reset with strap case i: codes 0 to 5 in soft mode, then hard mode
	task automatic do_reset(input int i);
		logic s;
		logic src;
		logic [5:0] l;
		logic [1:0] m;
		logic [6:0] a;
		logic [7:0] nr, rr;
		s = (i >= 6);
		src = 1'($random(seed));
		l = 6'($random(seed));
		m = s ? 2'h0 : 2'($random(seed));
		a = 7'($random(seed));
		nr = 8'($random(seed)) | 8'h01;
		rr = 8'($random(seed)) | 8'h01;
		if (!s) begin
			l[3] = (i > 2);
			l[2] = (i % 3 == 2);
			m[1] = (i % 3 == 1);
		end
		exp_soft = s ? 8'h80 : {1'b0, 3'(i), 4'h0};
		exp_hard = s ? {l, 2'h0} : 8'h00;
		exp_addr = {a[6:2], m[0] ? 2'h1 : {2{l[1]}}, 1'b0};
		exp_rev = src ? nr : rr;
		@(posedge clk_i);
		rst_i <= 1'b1;
		sel <= s;
		lvl <= l;
		mid <= m;
		nvm_bus_addr_i <= a;
		nvm_image_rev_i <= nr;
		rom_image_rev_i <= rr;
		image_src_nvm_i <= src;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_cycle(8'h2C, 1'b0, 8'h00);
	endtask

	task automatic stop_test();
		$display("Checks: %0d, errors: %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence: capture, hold, commit reload, ignored writes
	initial begin
		for (int i = 0; i < 12; i++) begin
			do_reset(i);
			read_all();
			@(posedge clk_i);
			sel <= ~sel;
			lvl <= ~lvl;
			mid <= 2'h0;
			nvm_image_rev_i <= ~nvm_image_rev_i;
			rom_image_rev_i <= ~rom_image_rev_i;
			image_src_nvm_i <= ~image_src_nvm_i;
			repeat (4) @(posedge clk_i);
			read_all();
			commit_done_i <= 1'b1;
			@(posedge clk_i);
			commit_done_i <= 1'b0;
			exp_rev = image_src_nvm_i ? nvm_image_rev_i : rom_image_rev_i;
			wb_cycle(8'h2C, 1'b0, exp_rev);
			for (int k = 0; k < 5; k++) begin
				wb_cycle(8'(8'h20 + 4 * k), 1'b1, 8'h00);
			end
			read_all();
			wb_cycle(8'h30, 1'b0, 8'h00);
		end
		@(posedge clk_i);
		stop_test();
	end

	// Watchdog against a hang
	initial begin
		#40000;
		num_errors++;
		$display("Error at %0t: timeout", $time);
		stop_test();
	end
endmodule
